// ### hw/rtc_time_pkg.sv
// Constants, register map and BCD helpers for the timekeeping counters
`default_nettype none
package rtc_time_pkg;
	// Register indices on the parallel register port
	localparam logic [2:0] ADDR_SECONDS      = 3'h0;
	localparam logic [2:0] ADDR_MINUTES      = 3'h1;
	localparam logic [2:0] ADDR_HOURS        = 3'h2;
	localparam logic [2:0] ADDR_WEEKDAY      = 3'h3;
	localparam logic [2:0] ADDR_MONTHDAY     = 3'h4;
	localparam logic [2:0] ADDR_MONTH        = 3'h5;
	localparam logic [2:0] ADDR_YEAR         = 3'h6;
	localparam logic [2:0] ADDR_RATE_ADJUST  = 3'h7;

	// Implemented bits of each register; the rest read as zero
	localparam logic [7:0] MASK_SECONDS      = 8'h7F;
	localparam logic [7:0] MASK_MINUTES      = 8'h7F;
	localparam logic [7:0] MASK_HOURS        = 8'h3F;
	localparam logic [7:0] MASK_WEEKDAY      = 8'h07;
	localparam logic [7:0] MASK_MONTHDAY     = 8'h3F;
	localparam logic [7:0] MASK_MONTH        = 8'h9F;
	localparam logic [7:0] MASK_YEAR         = 8'hFF;
	localparam logic [7:0] MASK_RATE_ADJUST  = 8'h7F;

	// Field positions
	localparam int         RATE_WRITE_GATE   = 7;
	localparam int         ADJUST_DIRECTION  = 6;
	localparam int         CENTURY_BIT       = 7;
	localparam int         HOUR_PM_BIT       = 5;

	// Reset values; the real counters are undefined after a halt
	localparam logic [7:0] RST_SECONDS       = 8'h00;
	localparam logic [7:0] RST_MINUTES       = 8'h00;
	localparam logic [7:0] RST_HOURS         = 8'h00;
	localparam logic [2:0] RST_WEEKDAY       = 3'h0;
	localparam logic [7:0] RST_MONTHDAY      = 8'h01;
	localparam logic [7:0] RST_MONTH         = 8'h01;
	localparam logic [7:0] RST_YEAR          = 8'h00;
	localparam logic [7:0] RST_RATE_ADJUST   = 8'h00;

	// BCD limits
	localparam logic [7:0] BCD_00            = 8'h00;
	localparam logic [7:0] BCD_01            = 8'h01;
	localparam logic [7:0] BCD_11            = 8'h11;
	localparam logic [7:0] BCD_12            = 8'h12;
	localparam logic [7:0] BCD_20            = 8'h20;
	localparam logic [7:0] BCD_23            = 8'h23;
	localparam logic [7:0] BCD_28            = 8'h28;
	localparam logic [7:0] BCD_29            = 8'h29;
	localparam logic [7:0] BCD_30            = 8'h30;
	localparam logic [7:0] BCD_31            = 8'h31;
	localparam logic [7:0] BCD_40            = 8'h40;
	localparam logic [7:0] BCD_59            = 8'h59;
	localparam logic [7:0] BCD_99            = 8'h99;
	localparam logic [2:0] WEEKDAY_LAST      = 3'h6;

	// Oscillator pulses in one unadjusted second
	localparam int         OSC_PER_SECOND    = 32768;
	localparam int         PRESCALE_WIDTH    = 16;

	// Adds one to a two-digit BCD value
	function automatic logic [7:0] bcd_plus1(input logic [7:0] value);
		logic [7:0] result;
		result = value;
		if (value[3:0] == 4'h9) begin
			result = {value[7:4] + 4'h1, 4'h0};
		end else begin
			result = {value[7:4], value[3:0] + 4'h1};
		end
		return result;
	endfunction : bcd_plus1
endpackage : rtc_time_pkg
`default_nettype wire

// ### hw/bcd_wrap_step.sv
// One BCD step with wrap from a last value back to a first value
`default_nettype none
module bcd_wrap_step (
	input  wire logic [7:0] value_i,
	input  wire logic [7:0] first_i,
	input  wire logic [7:0] last_i,
	output logic      [7:0] next_o,
	output logic            wrap_o
);
	import rtc_time_pkg::*;

	wire [7:0] plus_one;

	assign plus_one = bcd_plus1(value_i);
	assign wrap_o   = (value_i == last_i);
	assign next_o   = wrap_o ? first_i : plus_one;
endmodule : bcd_wrap_step
`default_nettype wire

// ### hw/rtc_time_calendar_counters.sv
// Time and calendar counters with rate adjustment for a real-time clock
// Notes on behaviour
// - seconds count 00..59, carry into minutes
// - minutes count 00..59, carry into hours
// - hour rollover carries into both day counters
// - seconds write clears the sub-second prescaler
// - time registers at 0..2, spare bits zero
// - twelve-hour mode: bit 5 is PM
// - weekday counts 0..6 modulo seven
// - month length by month and leap year
// - day wrap bumps month, month wraps carry year
// - year 00..99, multiples of four leap
// - century bit toggles on year 99 to 00
// - calendar registers at 4..6, spare bits zero
// - rate write needs bit 7 low; halt clears
// - adjust seconds starting at 00, 20, 40
// - no adjustment at boundary coinciding with write
// - direction low lengthens by (magnitude-1)*2
// - direction high shortens by (~magnitude+1)*2
// - zero magnitude means no change
`default_nettype none
module rtc_time_calendar_counters #(
	parameter int SECOND_PULSES = rtc_time_pkg::OSC_PER_SECOND
) (
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       osc_clk_i,
	input  wire logic       hour_mode_24_i,
	input  wire logic       osc_halt_flag_i,
	input  wire logic [2:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	output logic            second_tick_o
);
	import rtc_time_pkg::*;

	localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_LAST =
		PRESCALE_WIDTH'(SECOND_PULSES - 1);

	// Counter state
	logic [7:0]                seconds_count;
	logic [7:0]                minutes_count;
	logic [7:0]                hours_count;
	logic [2:0]                weekday_count;
	logic [7:0]                monthday_count;
	logic [7:0]                month_century_count;
	logic [7:0]                year_count;
	logic [7:0]                rate_adjust;
	logic [PRESCALE_WIDTH-1:0] prescale;
	logic                      adj_active;
	logic                      halt_prev;

	// Oscillator pin synchroniser and edge detector
	logic                      osc_sync1;
	logic                      osc_sync2;
	logic                      osc_prev;

	// Decode of register writes
	wire                       wr_seconds;
	wire                       wr_minutes;
	wire                       wr_hours;
	wire                       wr_weekday;
	wire                       wr_monthday;
	wire                       wr_month;
	wire                       wr_year;
	wire                       wr_rate;
	wire                       halt_rise;

	// Oscillator pulse and prescaler
	wire                       osc_pulse;
	wire [PRESCALE_WIDTH-1:0]  lengthen;
	wire [PRESCALE_WIDTH-1:0]  shorten;
	wire [PRESCALE_WIDTH-1:0]  prescale_end;
	wire                       second_tick;
	wire [PRESCALE_WIDTH-1:0]  next_prescale;

	// Carry chain
	wire [7:0]                 sec_step;
	wire                       sec_wrap;
	wire [7:0]                 min_step;
	wire                       min_wrap;
	wire [7:0]                 hour_step;
	wire                       hour_wrap;
	wire [7:0]                 hour12_step;
	wire [7:0]                 hour12_plus;
	wire [7:0]                 hour24_step;
	wire                       hour24_wrap;
	wire [7:0]                 mday_step;
	wire                       mday_wrap;
	wire [7:0]                 month_step;
	wire                       month_wrap;
	wire [7:0]                 year_step;
	wire                       year_wrap;
	wire [7:0]                 month_last_day;
	wire [7:0]                 month_bcd;
	wire                       leap_year;
	wire                       min_carry;
	wire                       hour_carry;
	wire                       day_carry;
	wire                       month_carry;
	wire                       year_carry;
	wire                       boundary;
	wire [7:0]                 read_mux;

	// Next values
	wire [7:0]                 next_seconds;
	wire [7:0]                 next_minutes;
	wire [7:0]                 next_hours;
	wire [2:0]                 next_weekday;
	wire [7:0]                 next_monthday;
	wire [7:0]                 next_month;
	wire [7:0]                 next_year;
	wire [7:0]                 next_rate_adjust;
	wire                       next_adj_active;

	assign wr_seconds  = reg_wr_i && (reg_addr_i == ADDR_SECONDS);
	assign wr_minutes  = reg_wr_i && (reg_addr_i == ADDR_MINUTES);
	assign wr_hours    = reg_wr_i && (reg_addr_i == ADDR_HOURS);
	assign wr_weekday  = reg_wr_i && (reg_addr_i == ADDR_WEEKDAY);
	assign wr_monthday = reg_wr_i && (reg_addr_i == ADDR_MONTHDAY);
	assign wr_month    = reg_wr_i && (reg_addr_i == ADDR_MONTH);
	assign wr_year     = reg_wr_i && (reg_addr_i == ADDR_YEAR);
	assign wr_rate     = reg_wr_i && (reg_addr_i == ADDR_RATE_ADJUST)
		&& !reg_wdata_i[RATE_WRITE_GATE];
	assign halt_rise   = osc_halt_flag_i && !halt_prev;

	assign osc_pulse   = osc_sync2 && !osc_prev;

	// Adjustment amounts in oscillator pulses
	assign lengthen = {{(PRESCALE_WIDTH-7){1'b0}},
		rate_adjust[5:0] - 6'h01, 1'b0};
	assign shorten  = {{(PRESCALE_WIDTH-8){1'b0}},
		{1'b0, ~rate_adjust[5:0]} + 7'h01, 1'b0};
	assign prescale_end = !adj_active ? PRESCALE_LAST :
		(rate_adjust[ADJUST_DIRECTION] ? PRESCALE_LAST - shorten
		: PRESCALE_LAST + lengthen);

	// A seconds write discards the partial second
	assign second_tick   = osc_pulse && !wr_seconds && (prescale == prescale_end);
	assign next_prescale = wr_seconds ? '0 :
		(osc_pulse ? (second_tick ? '0 : prescale + 1'b1) : prescale);

	bcd_wrap_step u_sec_step (
		.value_i (seconds_count),
		.first_i (BCD_00),
		.last_i  (BCD_59),
		.next_o  (sec_step),
		.wrap_o  (sec_wrap)
	);

	bcd_wrap_step u_min_step (
		.value_i (minutes_count),
		.first_i (BCD_00),
		.last_i  (BCD_59),
		.next_o  (min_step),
		.wrap_o  (min_wrap)
	);

	bcd_wrap_step u_hour24_step (
		.value_i (hours_count),
		.first_i (BCD_00),
		.last_i  (BCD_23),
		.next_o  (hour24_step),
		.wrap_o  (hour24_wrap)
	);

	// Twelve-hour sequence: 12,01..11 then 32,21..31 with PM set
	assign hour12_plus = bcd_plus1({3'b000, hours_count[4:0]});
	assign hour12_step = (hours_count[4:0] == BCD_12[4:0])
		? {2'b00, hours_count[HOUR_PM_BIT], BCD_01[4:0]}
		: (hours_count[4:0] == BCD_11[4:0])
		? {2'b00, !hours_count[HOUR_PM_BIT], BCD_12[4:0]}
		: {2'b00, hours_count[HOUR_PM_BIT],
		hour12_plus[4:0]};
	assign hour_wrap = hour_mode_24_i ? hour24_wrap
		: (hours_count == (BCD_11 | 8'h20));
	assign hour_step = hour_mode_24_i ? hour24_step : hour12_step;

	// Leap when the BCD year is a multiple of four, 00 included
	assign leap_year = year_count[4]
		? (year_count[3:0] == 4'h2 || year_count[3:0] == 4'h6)
		: (year_count[3:0] == 4'h0 || year_count[3:0] == 4'h4
		|| year_count[3:0] == 4'h8);

	assign month_bcd = {3'b000, month_century_count[4:0]};
	assign month_last_day = (month_bcd == 8'h02) ? (leap_year ? BCD_29 : BCD_28)
		: (month_bcd == 8'h04 || month_bcd == 8'h06 || month_bcd == 8'h09
		|| month_bcd == 8'h11) ? BCD_30 : BCD_31;

	bcd_wrap_step u_mday_step (
		.value_i (monthday_count),
		.first_i (BCD_01),
		.last_i  (month_last_day),
		.next_o  (mday_step),
		.wrap_o  (mday_wrap)
	);

	bcd_wrap_step u_month_step (
		.value_i (month_bcd),
		.first_i (BCD_01),
		.last_i  (BCD_12),
		.next_o  (month_step),
		.wrap_o  (month_wrap)
	);

	bcd_wrap_step u_year_step (
		.value_i (year_count),
		.first_i (BCD_00),
		.last_i  (BCD_99),
		.next_o  (year_step),
		.wrap_o  (year_wrap)
	);

	// Carry chain, all within the cycle of the second tick
	assign min_carry   = second_tick && sec_wrap;
	assign hour_carry  = min_carry && min_wrap;
	assign day_carry   = hour_carry && hour_wrap;
	assign month_carry = day_carry && mday_wrap;
	assign year_carry  = month_carry && month_wrap;

	// A write wins over a carry into the same register
	assign next_seconds = wr_seconds ? (reg_wdata_i & MASK_SECONDS)
		: (second_tick ? sec_step : seconds_count);
	assign next_minutes = wr_minutes ? (reg_wdata_i & MASK_MINUTES)
		: (min_carry ? min_step : minutes_count);
	assign next_hours = wr_hours ? (reg_wdata_i & MASK_HOURS)
		: (hour_carry ? hour_step : hours_count);
	assign next_weekday = wr_weekday ? reg_wdata_i[2:0]
		: (!day_carry ? weekday_count
		: (weekday_count == WEEKDAY_LAST) ? RST_WEEKDAY
		: weekday_count + 3'h1);
	assign next_monthday = wr_monthday ? (reg_wdata_i & MASK_MONTHDAY)
		: (day_carry ? mday_step : monthday_count);
	assign next_month = wr_month ? (reg_wdata_i & MASK_MONTH)
		: {month_century_count[CENTURY_BIT]
		^ (year_carry && year_wrap), 2'b00,
		month_carry ? month_step[4:0]
		: month_century_count[4:0]};
	assign next_year = wr_year ? (reg_wdata_i & MASK_YEAR)
		: (year_carry ? year_step : year_count);

	// Halt clears the adjust register even against a write
	assign next_rate_adjust = halt_rise ? RST_RATE_ADJUST
		: (wr_rate ? (reg_wdata_i & MASK_RATE_ADJUST)
		: rate_adjust);

	// Adjusted second starts as the count steps to 00, 20 or 40
	assign boundary = second_tick
		&& (sec_step == BCD_00 || sec_step == BCD_20
		|| sec_step == BCD_40);
	// A rate write during or at that second cancels it
	assign next_adj_active = (wr_rate || halt_rise) ? 1'b0
		: (boundary ? (rate_adjust[5:0] != 6'h00)
		: (second_tick ? 1'b0 : adj_active));

	// Unimplemented bits already zero in storage
	assign read_mux = (reg_addr_i == ADDR_SECONDS) ? seconds_count
		: (reg_addr_i == ADDR_MINUTES) ? minutes_count
		: (reg_addr_i == ADDR_HOURS) ? hours_count
		: (reg_addr_i == ADDR_WEEKDAY) ? {5'h00, weekday_count}
		: (reg_addr_i == ADDR_MONTHDAY) ? monthday_count
		: (reg_addr_i == ADDR_MONTH) ? month_century_count
		: (reg_addr_i == ADDR_YEAR) ? year_count
		: rate_adjust;

	// Oscillator comes from a pin, so two flops before any use
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_sync1 <= 1'b0;
			osc_sync2 <= 1'b0;
			osc_prev  <= 1'b0;
		end else begin
			osc_sync1 <= osc_clk_i;
			osc_sync2 <= osc_sync1;
			osc_prev  <= osc_sync2;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prescale   <= '0;
			adj_active <= 1'b0;
			halt_prev  <= 1'b0;
			rate_adjust <= RST_RATE_ADJUST;
		end else begin
			prescale   <= next_prescale;
			adj_active <= next_adj_active;
			halt_prev  <= osc_halt_flag_i;
			rate_adjust <= next_rate_adjust;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seconds_count       <= RST_SECONDS;
			minutes_count       <= RST_MINUTES;
			hours_count         <= RST_HOURS;
			weekday_count       <= RST_WEEKDAY;
			monthday_count      <= RST_MONTHDAY;
			month_century_count <= RST_MONTH;
			year_count          <= RST_YEAR;
		end else begin
			seconds_count       <= next_seconds;
			minutes_count       <= next_minutes;
			hours_count         <= next_hours;
			weekday_count       <= next_weekday;
			monthday_count      <= next_monthday;
			month_century_count <= next_month;
			year_count          <= next_year;
		end
	end

	// Registered read data: one cycle after the address
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o   <= 8'h00;
			second_tick_o <= 1'b0;
		end else begin
			reg_rdata_o   <= read_mux;
			second_tick_o <= second_tick;
		end
	end
endmodule : rtc_time_calendar_counters
`default_nettype wire

// ### test/rtc_host_model.sv
// Host side of the register port
`default_nettype none
module rtc_host_model (
	input  wire logic       clock_i,
	input  wire logic [7:0] reg_rdata_i,
	output var  logic [2:0] reg_addr_o,
	output var  logic       reg_wr_o,
	output var  logic [7:0] reg_wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_addr_o = 3'h0;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
	end
	// One-cycle strobe; data inverted after so stale data never looks valid
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clock_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clock_i);
		reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(negedge clock_i);
		reg_addr_o = a;
		@(negedge clock_i);
		d = reg_rdata_i;
	endtask : rd
endmodule : rtc_host_model
`default_nettype wire

// ### test/rtc_time_calendar_counters_asserts.sv
// Port checker for the timekeeping counters
`default_nettype none
module rtc_time_calendar_counters_chk import rtc_time_pkg::*; (
	input wire logic       clock_i,
	input wire logic       rst_n_i,
	input wire logic       osc_clk_i,
	input wire logic       hour_mode_24_i,
	input wire logic       osc_halt_flag_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic       reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       second_tick_o
);
	logic [2:0] addr_q;
	logic       osc_q;
	logic [3:0] osc_age;
	// Age saturates so an idle oscillator never wraps back to young
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_q <= 3'h0;
			osc_q <= 1'b0;
			osc_age <= 4'hF;
		end else begin
			addr_q <= reg_addr_i;
			osc_q <= osc_clk_i;
			osc_age <= (osc_clk_i && !osc_q) ? 4'h0 : osc_age + {3'h0, osc_age != 4'hF};
		end
	end
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	a_tick_lone_pulse: assert property (
		second_tick_o |-> (osc_age <= 4'd6) ##1 (!second_tick_o) [*8])
		else $error("second tick not a lone pulse after an oscillator edge");
	a_sec_bcd_range: assert property (
		second_tick_o && reg_addr_i == ADDR_SECONDS |=>
		reg_rdata_o[3:0] <= 4'h9 && reg_rdata_o[7:4] <= 4'h5)
		else $error("seconds left 00 to 59 after a tick");
	a_weekday_wrap: assert property (
		second_tick_o && reg_addr_i == ADDR_WEEKDAY |=> reg_rdata_o <= 8'h06)
		else $error("weekday beyond 6 after a tick");
	a_sec_readback: assert property (
		reg_wr_i && reg_addr_i == ADDR_SECONDS ##1 reg_addr_i == ADDR_SECONDS && !reg_wr_i
		|=> reg_rdata_o == ($past(reg_wdata_i, 2) & MASK_SECONDS))
		else $error("seconds write not read back");
	a_sec_write_quiet: assert property (
		reg_wr_i && reg_addr_i == ADDR_SECONDS |-> ##2 (!second_tick_o) [*8])
		else $error("tick soon after a seconds write");
	a_rate_gate: assert property (
		reg_wr_i && reg_addr_i == ADDR_RATE_ADJUST && reg_wdata_i[7] && !osc_halt_flag_i
		##1 reg_addr_i == ADDR_RATE_ADJUST && !reg_wr_i && !$rose(osc_halt_flag_i)
		|=> $stable(reg_rdata_o))
		else $error("rate write with top bit set took effect");
	a_halt_clear: assert property (
		$rose(osc_halt_flag_i) ##1 reg_addr_i == ADDR_RATE_ADJUST && !reg_wr_i
		|=> reg_rdata_o == 8'h00)
		else $error("halt did not clear rate register");
	a_hour_spare: assert property (addr_q == ADDR_HOURS |-> reg_rdata_o[7:6] == 2'b00)
		else $error("hour spare bits not zero");
	a_month_spare: assert property (addr_q == ADDR_MONTH |-> reg_rdata_o[6:5] == 2'b00)
		else $error("month spare bits not zero");
endmodule : rtc_time_calendar_counters_chk
bind rtc_time_calendar_counters rtc_time_calendar_counters_chk chk_i (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .osc_clk_i(osc_clk_i),
	.hour_mode_24_i(hour_mode_24_i), .osc_halt_flag_i(osc_halt_flag_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .second_tick_o(second_tick_o));
`default_nettype wire

// ### test/rtc_time_calendar_counters_tb_top.sv
// Self-checking bench for the timekeeping counters
`default_nettype none
module rtc_time_calendar_counters_tb_top import rtc_time_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// Short second keeps the run brief; the setup phase must fit inside one
	localparam int SEC_PULSES = 2048;
	logic        clock;
	logic        rst_n;
	logic        osc = 1'b0;
	logic        halt;
	logic        mode24;
	logic        tick;
	logic        wr;
	logic [2:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic [7:0]  got;
	logic [31:0] lfsr;
	int          n_errors;
	int          num_checks;
	int          cycles = 0;
	int          t0;
	int          t1;
	int          mdl [8];
	logic [7:0]  masks [7] = '{MASK_SECONDS, MASK_MINUTES, MASK_HOURS, MASK_WEEKDAY,
		MASK_MONTHDAY, MASK_MONTH, MASK_YEAR};
	int          cal [7] = '{'h59, 'h59, 'h31, 6, 'h31, 'h12, 'h99};
	rtc_time_calendar_counters #(.SECOND_PULSES(SEC_PULSES)) rtc_time_calendar_counters_i (
		.clock_i(clock), .rst_n_i(rst_n), .osc_clk_i(osc), .hour_mode_24_i(mode24),
		.osc_halt_flag_i(halt), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .second_tick_o(tick));
	rtc_host_model rtc_host_model_i (.clock_i(clock), .reg_rdata_i(rdata),
		.reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Fastest pulse train the synchroniser can follow, to keep a second short
	always @(negedge clock) osc <= ~osc;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_errors++;
			results();
		end
	end
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction : next_rand
	function automatic int b2i(input int v);
		return (v >> 4 & 15) * 10 + (v & 15);
	endfunction : b2i
	function automatic int i2b(input int v);
		return (v / 10) << 4 | v % 10;
	endfunction : i2b
	function automatic int second_len(input int r);
		int m;
		m = r & 'h3F;
		if (m == 0) begin
			return SEC_PULSES;
		end
		return r[6] ? SEC_PULSES - ((~m & 'h3F) + 1) * 2
			: SEC_PULSES + (m - 1) * 2;
	endfunction : second_len
	function automatic void step_model();
		int h;
		int d;
		int mo;
		int y;
		int last;
		if (mdl[0] != 'h59) begin
			mdl[0] = i2b(b2i(mdl[0]) + 1);
			return;
		end
		mdl[0] = 0;
		if (mdl[1] != 'h59) begin
			mdl[1] = i2b(b2i(mdl[1]) + 1);
			return;
		end
		mdl[1] = 0;
		h = b2i(mdl[2] & 'h1F);
		if (mode24 ? mdl[2] != 'h23 : h != 11) begin
			mdl[2] = mode24 ? i2b(b2i(mdl[2]) + 1)
				: mdl[2] & 'h20 | i2b(h % 12 + 1);
			return;
		end
		mdl[2] = mode24 ? 0 : (mdl[2] ^ 'h20) & 'h20 | 'h12;
		if (mdl[2] == 'h32) begin
			return;
		end
		mdl[3] = (mdl[3] + 1) % 7;
		d = b2i(mdl[4]) + 1;
		mo = b2i(mdl[5] & 'h1F);
		y = b2i(mdl[6]);
		last = mo == 2 ? (y % 4 == 0 ? 29 : 28) :
			(mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
		if (d <= last) begin
			mdl[4] = i2b(d);
			return;
		end
		mdl[4] = 1;
		mdl[5] = mdl[5] & 'h80 | i2b(mo % 12 + 1);
		if (mo == 12) begin
			mdl[6] = i2b((y + 1) % 100);
			mdl[5] = y == 99 ? mdl[5] ^ 'h80 : mdl[5];
		end
	endfunction : step_model
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk
	task automatic check_all();
		for (int a = 0; a < 8; a++) begin
			rtc_host_model_i.rd(3'(a), got);
			chk($sformatf("reg%0d", a), mdl[a], {24'h0, got});
		end
	endtask : check_all
	task automatic wait_tick();
		while (tick !== 1'b1) begin
			@(negedge clock);
		end
		t0 = t1;
		t1 = cycles;
	endtask : wait_tick
	task automatic results();
		if (n_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	initial begin
		rst_n = 1'b0;
		halt = 1'b0;
		mode24 = 1'b0;
		n_errors = 0;
		num_checks = 0;
		lfsr = 32'h998DC4A1;
		mdl = '{RST_SECONDS, RST_MINUTES, RST_HOURS, RST_WEEKDAY, RST_MONTHDAY,
			RST_MONTH, RST_YEAR, RST_RATE_ADJUST};
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		check_all();
		for (int a = 0; a < 7; a++) begin
			lfsr = next_rand(lfsr);
			got = lfsr[7:0];
			if (a == 3) begin
				got[2:0] = 3'(got[2:0] % 7);
			end
			rtc_host_model_i.wr(3'(a), got);
			mdl[a] = got & masks[a];
		end
		mdl[7] = {1'b0, lfsr[14:8]};
		rtc_host_model_i.wr(ADDR_RATE_ADJUST, 8'(mdl[7]));
		rtc_host_model_i.wr(ADDR_RATE_ADJUST, 8'hFF);
		check_all();
		halt = 1'b1;
		repeat (2) @(negedge clock);
		mdl[7] = 0;
		check_all();
		halt = 1'b0;
		mdl[7] = 'h7E;
		rtc_host_model_i.wr(ADDR_RATE_ADJUST, 8'h7E);
		for (int a = 1; a < 7; a++) begin
			mdl[a] = cal[a];
			rtc_host_model_i.wr(3'(a), 8'(cal[a]));
		end
		// Prescaler runs meanwhile; the seconds write must restart it
		repeat (2000) @(negedge clock);
		mdl[0] = 'h59;
		rtc_host_model_i.wr(ADDR_SECONDS, 8'h59);
		t1 = cycles;
		rtc_host_model_i.rd(ADDR_WEEKDAY, got);
		wait_tick();
		t0 = t1 - t0;
		t0 = (t0 inside {[2 * SEC_PULSES - 2:2 * SEC_PULSES + 2]}) ? 2 * SEC_PULSES : t0;
		chk("first second", 2 * SEC_PULSES, t0);
		step_model();
		check_all();
		rtc_host_model_i.rd(ADDR_SECONDS, got);
		wait_tick();
		chk("adjusted second", 2 * second_len(mdl[7]), t1 - t0);
		step_model();
		check_all();
		// Same midnight rollover in 24-hour mode
		mode24 = 1'b1;
		mdl[2] = 'h23;
		rtc_host_model_i.wr(ADDR_HOURS, 8'h23);
		mdl[1] = 'h59;
		rtc_host_model_i.wr(ADDR_MINUTES, 8'h59);
		mdl[0] = 'h59;
		rtc_host_model_i.wr(ADDR_SECONDS, 8'h59);
		rtc_host_model_i.rd(ADDR_WEEKDAY, got);
		wait_tick();
		step_model();
		check_all();
		results();
	end
endmodule : rtc_time_calendar_counters_tb_top
`default_nettype wire
